// File: nvap_pkg.sv
/*
  nvap_pkg: constants and carrier types for the nonvolatile store access port.
  assumes a single 200 MHz cpu clock domain; cpu reaches registers by I/O index.
*/
package nvap_pkg;

  // I/O register indices of the access port
  localparam logic [5:0] IO_NV_CONTROL      = 6'h1f;
  localparam logic [5:0] IO_NV_DATA_BYTE    = 6'h20;
  localparam logic [5:0] IO_NV_ADDRESS_LOW  = 6'h21;
  localparam logic [5:0] IO_NV_ADDRESS_HIGH = 6'h22;

  // store geometry
  localparam int unsigned STORE_BYTES  = 1024;
  localparam int unsigned ADDR_W       = 12;
  localparam int unsigned CELL_ADDR_W  = 10;
  localparam logic [11:0] LAST_STORE_LOCATION = 12'h3ff;
  localparam logic [3:0]  ADDR_HIGH_MASK      = 4'hf;

  // control register fields
  localparam int unsigned CTL_READ_STROBE_BIT  = 0;
  localparam int unsigned CTL_WRITE_STROBE_BIT = 1;
  localparam int unsigned CTL_ARM_BIT          = 2;
  localparam int unsigned CTL_READY_IE_BIT     = 3;
  localparam int unsigned CTL_MODE_LO_BIT      = 4;
  localparam int unsigned CTL_MODE_HI_BIT      = 5;
  localparam logic [1:0]  MODE_RESET           = 2'h0;

  // programming modes
  localparam logic [1:0] MODE_ERASE_WRITE = 2'h0;
  localparam logic [1:0] MODE_ERASE_ONLY  = 2'h1;
  localparam logic [1:0] MODE_WRITE_ONLY  = 2'h2;
  localparam logic [7:0] ERASED_BYTE      = 8'hff;

  // timing
  localparam int unsigned CLK_MHZ            = 200;
  localparam int unsigned ARM_WINDOW_CYC     = 4;
  localparam int unsigned READ_STALL_CYC     = 4;
  localparam int unsigned WRITE_STALL_CYC    = 2;
  localparam int unsigned OSC_CYC_PER_WRITE  = 26368;
  localparam int unsigned T_ERASE_WRITE_US   = 3400;
  localparam int unsigned T_SINGLE_US        = 1800;
  localparam int unsigned ERASE_WRITE_CYC    = T_ERASE_WRITE_US * CLK_MHZ;
  localparam int unsigned SINGLE_CYC         = T_SINGLE_US * CLK_MHZ;
  localparam int unsigned OSC_DIV_DEFAULT    = ERASE_WRITE_CYC / OSC_CYC_PER_WRITE;

  // cpu I/O access carrier
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } nvap_io_req_t;

  // request to the storage array
  typedef struct packed {
    logic                   wr;
    logic [1:0]             mode;
    logic [CELL_ADDR_W-1:0] addr;
    logic [7:0]             data;
  } nvap_cell_req_t;

endpackage

// File: nvap_store.sv
/*
  nvap_store: 1K byte array holding the nonvolatile data.
  assumes the caller keeps address and data stable and issues one request at a time.
*/
`timescale 1ns/10ps
module nvap_store (
  // clock
  input  wire logic                   clk_sys_i,
  input  wire logic                   ce_i,
  // request
  input  wire nvap_pkg::nvap_cell_req_t req_i,
  // read data
  output logic [7:0]                  rdata_o
);

  logic [7:0] cells [nvap_pkg::STORE_BYTES];
  logic [7:0] next_cell;

  // erase forces the erased pattern; write only can only clear bits
  always_comb begin
    case (req_i.mode)
      nvap_pkg::MODE_ERASE_ONLY: next_cell = nvap_pkg::ERASED_BYTE;
      nvap_pkg::MODE_WRITE_ONLY: next_cell = cells[req_i.addr] & req_i.data;
      default:                   next_cell = req_i.data;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (ce_i && req_i.wr) begin
      cells[req_i.addr] <= next_cell;
    end
  end

  assign rdata_o = cells[req_i.addr];

endmodule // nvap_store

// File: nvap_port.sv
/*
  nvap_port: cpu-side access port for the 1K byte nonvolatile data store.
  assumes cpu I/O accesses are synchronous to clk_sys_i and one-cycle wide,
  and that the cpu holds its pipeline while stall_o is high.
*/
// Notes on behaviour
// RULE1: separate 1K byte store, each byte read or written alone.
// RULE2: address, data and control registers sit in cpu I/O space.
// RULE3: programming self-timed; write strobe bit shows completion.
// RULE4: write starts only after the armed two-step sequence; lone strobe ignored.
// RULE5: a read stalls the cpu four cycles.
// RULE6: a write start stalls the cpu two cycles.
// RULE7: address bits 15..12 read zero, writes ignored.
// RULE8: address bits 11..0 select a byte linearly up to last location.
// RULE9: address undefined after reset; software writes it before access.
// RULE10: write programs data register byte at the addressed location.
// RULE11: read loads data register with the addressed byte.
// RULE12: arm lets strobe start within four cycles, then self-clears.
// RULE13: write strobe bit stays set while programming, cleared by hardware.
// RULE14: mode 00 erase+write 3.4 ms, 01 erase 1.8 ms, 10 write 1.8 ms.
// RULE15: write timed in 26,368 oscillator ticks.
// RULE16: read strobe fetches byte into data register before stall ends.
// RULE17: during programming, read strobes and address writes are ignored.
`timescale 1ns/10ps
module nvap_port #(
  parameter int unsigned OSC_DIV = nvap_pkg::OSC_DIV_DEFAULT
) (
  // clock and reset
  input  wire logic                  clk_sys_i,
  input  wire logic                  arst_n_i,
  input  wire logic                  ce_i,
  // cpu I/O access
  input  wire nvap_pkg::nvap_io_req_t io_req_i,
  output logic [7:0]                 io_rdata_o,
  output logic                       stall_o,
  // status
  output logic                       busy_o,
  output logic                       ready_irq_o
);

  typedef enum logic [1:0] {NVAP_IDLE, NVAP_PROG} nvap_state_t;

  nvap_state_t  state, next_state;
  logic [11:0]  address, next_address;
  logic [7:0]   data_byte, next_data_byte;
  logic [1:0]   mode, next_mode;
  logic         ready_ie, next_ready_ie;
  logic [2:0]   arm_cnt, next_arm_cnt;
  logic [2:0]   stall_cnt, next_stall_cnt;
  logic [15:0]  div_cnt, next_div_cnt;
  logic [14:0]  tick_cnt, next_tick_cnt;
  logic [14:0]  tick_goal, next_tick_goal;
  logic [7:0]   next_rdata;
  logic         cell_wr;
  logic [7:0]   cell_rdata;
  nvap_pkg::nvap_cell_req_t cell_req;

  // one-cycle I/O decode shared by the register writes and the readback
  function automatic logic hit(input logic [5:0] idx);
    hit = io_req_i.addr == idx;
  endfunction

  // scale oscillator ticks to the programming time of each mode
  function automatic logic [14:0] ticks_for(input logic [1:0] m);
    if (m == nvap_pkg::MODE_ERASE_WRITE) begin
      ticks_for = 15'(nvap_pkg::OSC_CYC_PER_WRITE);
    end else begin
      ticks_for = 15'(nvap_pkg::OSC_CYC_PER_WRITE * nvap_pkg::T_SINGLE_US / nvap_pkg::T_ERASE_WRITE_US);
    end
  endfunction

  wire logic ctl_wr   = io_req_i.wr && hit(nvap_pkg::IO_NV_CONTROL);
  wire logic prog     = state == NVAP_PROG;
  wire logic armed    = arm_cnt != 3'h0;
  // a start takes its mode from the strobe write itself, so timer and array agree
  wire logic [1:0] wr_mode = io_req_i.wdata[nvap_pkg::CTL_MODE_HI_BIT:nvap_pkg::CTL_MODE_LO_BIT];
  wire logic start_wr = ctl_wr && io_req_i.wdata[nvap_pkg::CTL_WRITE_STROBE_BIT] && armed && !prog
                        && wr_mode != 2'h3;
  wire logic start_rd = ctl_wr && io_req_i.wdata[nvap_pkg::CTL_READ_STROBE_BIT] && !prog && !start_wr;

  always_comb begin
    next_state     = state;
    next_address   = address;
    next_data_byte = data_byte;
    next_mode      = mode;
    next_ready_ie  = ready_ie;
    next_arm_cnt   = armed ? arm_cnt - 3'h1 : 3'h0;
    next_stall_cnt = stall_cnt != 3'h0 ? stall_cnt - 3'h1 : 3'h0;
    next_div_cnt   = div_cnt;
    next_tick_cnt  = tick_cnt;
    next_tick_goal = tick_goal;
    cell_wr        = 1'b0;
    // RULE2: I/O register writes
    if (io_req_i.wr && hit(nvap_pkg::IO_NV_DATA_BYTE)) begin
      // data stays writable while busy; the commit takes the byte held at the end
      next_data_byte = io_req_i.wdata;
    end else if (io_req_i.wr && hit(nvap_pkg::IO_NV_ADDRESS_LOW) && !prog) begin
      // RULE17 address frozen
      next_address[7:0] = io_req_i.wdata;
    end else if (io_req_i.wr && hit(nvap_pkg::IO_NV_ADDRESS_HIGH) && !prog) begin
      // RULE7 high nibble dropped
      next_address[11:8] = io_req_i.wdata[3:0];
    end else if (ctl_wr) begin
      next_ready_ie = io_req_i.wdata[nvap_pkg::CTL_READY_IE_BIT];
      if (!prog) begin
        next_mode = wr_mode;
      end
      // every arm write without the write strobe bit reloads the window, so a retry never inherits a stale count
      // RULE12 arm window
      if (io_req_i.wdata[nvap_pkg::CTL_ARM_BIT] && !io_req_i.wdata[nvap_pkg::CTL_WRITE_STROBE_BIT]) begin
        next_arm_cnt = 3'(nvap_pkg::ARM_WINDOW_CYC);
      end
    end
    // RULE4 armed start only
    if (start_wr) begin
      next_state     = NVAP_PROG;
      next_arm_cnt   = 3'h0;
      next_div_cnt   = 16'h0;
      next_tick_cnt  = 15'h0;
      // RULE14 mode timing
      next_tick_goal = ticks_for(wr_mode);
      // RULE6 two cycle stall
      next_stall_cnt = 3'(nvap_pkg::WRITE_STALL_CYC);
    end
    // one stall counter serves both strobes; the cpu issues nothing while it runs
    // RULE5 four cycle stall
    if (start_rd) begin
      next_stall_cnt = 3'(nvap_pkg::READ_STALL_CYC);
      // RULE11 read into data byte
      // RULE16 ready before stall ends
      next_data_byte = cell_rdata;
    end
    // divider stands in for the calibrated oscillator; OSC_DIV is clocks per tick
    // RULE15 oscillator tick count
    if (prog) begin
      if (div_cnt == 16'(OSC_DIV - 1)) begin
        next_div_cnt  = 16'h0;
        next_tick_cnt = tick_cnt + 15'h1;
      end else begin
        next_div_cnt = div_cnt + 16'h1;
      end
      // RULE13 hardware clears strobe
      if (tick_cnt == tick_goal) begin
        // RULE10 commit data byte
        cell_wr    = 1'b1;
        next_state = NVAP_IDLE;
      end
    end
  end

  // RULE1 byte array
  // RULE8 linear low address bits
  assign cell_req = '{wr: cell_wr, mode: mode, addr: address[nvap_pkg::CELL_ADDR_W-1:0], data: data_byte};

  nvap_store u_store (
    .clk_sys_i (clk_sys_i),
    .ce_i      (ce_i),
    .req_i     (cell_req),
    .rdata_o   (cell_rdata)
  );

  // read data follows this cycle's writes, so a read right after a write needs no gap
  always_comb begin
    next_rdata = 8'h0;
    if (hit(nvap_pkg::IO_NV_DATA_BYTE)) begin
      next_rdata = start_rd ? cell_rdata : next_data_byte;
    end else if (hit(nvap_pkg::IO_NV_ADDRESS_LOW)) begin
      next_rdata = next_address[7:0];
    end else if (hit(nvap_pkg::IO_NV_ADDRESS_HIGH)) begin
      next_rdata = {4'h0, next_address[11:8]};
    end else if (hit(nvap_pkg::IO_NV_CONTROL)) begin
      // RULE3 strobe bit is completion flag
      next_rdata = {2'h0, next_mode, next_ready_ie, next_arm_cnt != 3'h0, next_state == NVAP_PROG, 1'b0};
    end
  end

  // RULE9 address has no reset value
  always_ff @(posedge clk_sys_i) begin
    if (ce_i) begin
      address   <= next_address;
      data_byte <= next_data_byte;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state       <= NVAP_IDLE;
      mode        <= nvap_pkg::MODE_RESET;
      ready_ie    <= 1'b0;
      arm_cnt     <= 3'h0;
      stall_cnt   <= 3'h0;
      div_cnt     <= 16'h0;
      tick_cnt    <= 15'h0;
      tick_goal   <= 15'h0;
    end else if (ce_i) begin
      state       <= next_state;
      mode        <= next_mode;
      ready_ie    <= next_ready_ie;
      arm_cnt     <= next_arm_cnt;
      stall_cnt   <= next_stall_cnt;
      div_cnt     <= next_div_cnt;
      tick_cnt    <= next_tick_cnt;
      tick_goal   <= next_tick_goal;
    end
  end

  // outputs held in their own flops so the cpu never sees decode glitches
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      io_rdata_o  <= 8'h0;
      stall_o     <= 1'b0;
      busy_o      <= 1'b0;
      ready_irq_o <= 1'b0;
    end else if (ce_i) begin
      io_rdata_o  <= next_rdata;
      stall_o     <= next_stall_cnt != 3'h0;
      busy_o      <= next_state == NVAP_PROG;
      // level request while idle and enabled
      ready_irq_o <= next_ready_ie && next_state != NVAP_PROG;
    end
  end

endmodule // nvap_port

// File: nvap_port_monitor.sv
/*
  nvap_port_monitor: port-level assertions for nvap_port.
  assumes one clock domain; attached by the bind after the module.
*/
`timescale 1ns/10ps
module nvap_port_monitor #(
  parameter int unsigned OSC_DIV = 1
) (
  // clock and reset
  input wire logic                   clk_sys_i,
  input wire logic                   arst_n_i,
  input wire logic                   ce_i,
  // cpu side
  input wire nvap_pkg::nvap_io_req_t io_req_i,
  input wire logic [7:0]             io_rdata_o,
  input wire logic                   stall_o,
  input wire logic                   busy_o,
  input wire logic                   ready_irq_o
);
  // loose bounds: a single op is about half of an erase plus write
  localparam int MIN_BUSY = 13950;
  localparam int MAX_BUSY = 26380;
  logic        ctl_wr;
  logic        arm_wr;
  logic        strobe_wr;
  logic        any_strobe;
  logic [2:0]  arm_age;
  logic [2:0]  next_arm_age;
  logic [31:0] busy_cnt;
  logic [31:0] next_busy_cnt;
  assign ctl_wr = ce_i && io_req_i.wr && io_req_i.addr == nvap_pkg::IO_NV_CONTROL;
  assign arm_wr = ctl_wr && io_req_i.wdata[2];
  assign strobe_wr = ctl_wr && io_req_i.wdata[1];
  assign any_strobe = ctl_wr && io_req_i.wdata[1:0] != 2'h0;
  always_comb begin
    next_arm_age = arm_wr ? 3'h0 : ((arm_age == 3'h7) ? arm_age : arm_age + 3'h1);
    next_busy_cnt = busy_o ? busy_cnt + 32'h1 : 32'h0;
  end
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      arm_age <= 3'h7;
      busy_cnt <= 32'h0;
    end else if (ce_i) begin
      arm_age <= next_arm_age;
      busy_cnt <= next_busy_cnt;
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_read_hold;
    stall_o [*4] ##1 !stall_o;
  endsequence
  sequence s_write_hold;
    stall_o [*2] ##1 !stall_o;
  endsequence
  a_read_stall: assert property (ctl_wr && io_req_i.wdata[1:0] == 2'h1 && !busy_o && !stall_o |=> s_read_hold)
    else $error("read stall length wrong");
  a_write_stall: assert property ($rose(busy_o) |-> s_write_hold)
    else $error("write stall length wrong");
  a_arm_window: assert property ($rose(busy_o) |-> $past(strobe_wr) && arm_age <= 3'h4)
    else $error("write started without live arm");
  a_busy_time: assert property ($fell(busy_o) |-> busy_cnt >= MIN_BUSY * OSC_DIV && busy_cnt <= MAX_BUSY * OSC_DIV)
    else $error("programming time out of range");
  a_mode_reserved: assert property (ctl_wr && io_req_i.wdata[5:4] == 2'h3 && io_req_i.wdata[1] && !busy_o |=> !busy_o)
    else $error("reserved mode started a write");
  a_stall_cause: assert property ($rose(stall_o) |-> $past(any_strobe))
    else $error("stall without strobe");
  a_high_zero: assert property (ce_i && io_req_i.addr == nvap_pkg::IO_NV_ADDRESS_HIGH |=> io_rdata_o[7:4] == 4'h0)
    else $error("reserved address bits not zero");
  a_unmapped_zero: assert property (ce_i && (io_req_i.addr < 6'h1f || io_req_i.addr > 6'h22) |=> io_rdata_o == 8'h00)
    else $error("unmapped index read not zero");
endmodule // nvap_port_monitor

bind nvap_port nvap_port_monitor #(.OSC_DIV(OSC_DIV)) u_mon (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
  .ce_i(ce_i), .io_req_i(io_req_i), .io_rdata_o(io_rdata_o), .stall_o(stall_o), .busy_o(busy_o),
  .ready_irq_o(ready_irq_o));

// File: nvap_cpu_model.sv
/*
  nvap_cpu_model: cpu core issuing one-cycle I/O accesses.
  assumes the port answers one cycle after a request.
*/
`timescale 1ns/10ps
module nvap_cpu_model (
  // clock
  input  wire logic             clk_sys_i,
  // port side
  input  wire logic [7:0]       io_rdata_i,
  input  wire logic             stall_i,
  output nvap_pkg::nvap_io_req_t io_req_o
);
  int gap = 0;
  int hangs = 0;
  initial io_req_o = '0;
  task automatic io_wr(input logic [5:0] a, input logic [7:0] d);
    int n;
    repeat (gap) @(posedge clk_sys_i);
    io_req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys_i);
    io_req_o.wr <= 1'b0;
    @(posedge clk_sys_i);
    n = 0;
    while (stall_i === 1'b1 && n < 8) begin
      @(posedge clk_sys_i);
      n++;
    end
    if (n == 8) hangs++;
  endtask
  task automatic io_rd(input logic [5:0] a, output logic [7:0] d);
    io_req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_sys_i);
    io_req_o.rd <= 1'b0;
    @(posedge clk_sys_i);
    d = io_rdata_i;
  endtask
  task automatic prog(input logic [11:0] a, input logic [7:0] d, input logic [1:0] m);
    io_wr(nvap_pkg::IO_NV_ADDRESS_LOW, a[7:0]);
    io_wr(nvap_pkg::IO_NV_ADDRESS_HIGH, {4'hf, a[11:8]});
    io_wr(nvap_pkg::IO_NV_DATA_BYTE, d);
    io_wr(nvap_pkg::IO_NV_CONTROL, {2'h0, m, 4'h4});
    io_wr(nvap_pkg::IO_NV_CONTROL, {2'h0, m, 4'h2});
  endtask
endmodule // nvap_cpu_model

// File: test_eeprom_access_port.sv
/*
  test_eeprom_access_port: self-checking bench for nvap_port.
  assumes OSC_DIV of 1 so a write lasts tens of thousands of cycles.
*/
`timescale 1ns/10ps
module test_eeprom_access_port;
  localparam int unsigned DIV = 1;
  typedef struct {logic [1:0] m; logic [7:0] d; logic [7:0] e; int t;} nvap_row_t;
  nvap_row_t rows [4] = '{'{2'h0, 8'h5a, 8'h5a, 26368}, '{2'h1, 8'h00, 8'hff, 13959},
                          '{2'h2, 8'h3c, 8'h3c, 13959}, '{2'h3, 8'h00, 8'h3c, 0}};
  logic                   clk_sys_i = 1'b0;
  logic                   arst_n_i = 1'b0;
  logic                   ce_i = 1'b1;
  nvap_pkg::nvap_io_req_t io_req;
  logic [7:0]             rdata;
  logic [7:0]             v;
  logic                   stall;
  logic                   busy;
  logic                   irq;
  int                     err_total = 0;
  int                     tests_run = 0;
  always #2.5 clk_sys_i = ~clk_sys_i;
  nvap_port #(.OSC_DIV(DIV)) dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .ce_i(ce_i), .io_req_i(io_req),
    .io_rdata_o(rdata), .stall_o(stall), .busy_o(busy), .ready_irq_o(irq));
  nvap_cpu_model u_cpu (.clk_sys_i(clk_sys_i), .io_rdata_i(rdata), .stall_i(stall), .io_req_o(io_req));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_rng(input string n, input int lo, input int hi, input int g);
    tests_run++;
    if (g < lo || g > hi) begin
      err_total++;
      $display("[ERR] %s expected %0d..%0d seen %0d", n, lo, hi, g);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, err_total + u_cpu.hangs);
    if (err_total + u_cpu.hangs == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // waits out programming; a hang ends the run
  task automatic wait_idle(output int n);
    n = 0;
    while (busy !== 1'b0 && n < 30000) begin
      @(posedge clk_sys_i);
      n++;
    end
    if (n >= 30000) begin
      err_total++;
      end_of_test();
    end
  endtask
  initial begin
    int n;
    repeat (20) @(posedge clk_sys_i);
    chk("reset_outputs", 3'h0, {stall, busy, irq}); // RESET
    arst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    foreach (rows[i]) begin
      u_cpu.prog(12'h3ff, rows[i].d, rows[i].m);
      chk("busy", rows[i].m != 2'h3, busy);
      u_cpu.io_rd(nvap_pkg::IO_NV_CONTROL, v);
      chk("ctl_busy_bit", rows[i].m != 2'h3, v[1]);
      wait_idle(n);
      chk_rng("busy_time", rows[i].t * DIV - 12, rows[i].t * DIV + 4, n);
      u_cpu.io_wr(nvap_pkg::IO_NV_CONTROL, 8'h01);
      u_cpu.io_rd(nvap_pkg::IO_NV_DATA_BYTE, v);
      chk("data", rows[i].e, v);
      $display("row %0d done", i);
    end
    u_cpu.io_rd(nvap_pkg::IO_NV_ADDRESS_HIGH, v);
    chk("addr_high", 8'h03, v);
    u_cpu.io_wr(6'h23, 8'h55);
    u_cpu.io_rd(6'h23, v);
    chk("unmapped", 8'h00, v);
    u_cpu.io_wr(nvap_pkg::IO_NV_CONTROL, 8'h02);
    chk("lone_strobe", 1'b0, busy);
    u_cpu.gap = 3;
    u_cpu.prog(12'h000, 8'h11, 2'h0);
    chk("late_strobe", 1'b0, busy);
    u_cpu.gap = 0;
    $display("refusal test done");
    u_cpu.prog(12'h3ff, 8'h00, 2'h1);
    u_cpu.io_wr(nvap_pkg::IO_NV_ADDRESS_LOW, 8'h00);
    u_cpu.io_wr(nvap_pkg::IO_NV_CONTROL, 8'h01);
    u_cpu.io_rd(nvap_pkg::IO_NV_DATA_BYTE, v);
    chk("busy_read_ignored", 8'h00, v);
    u_cpu.io_rd(nvap_pkg::IO_NV_ADDRESS_LOW, v);
    chk("busy_addr_ignored", 8'hff, v);
    wait_idle(n);
    u_cpu.io_wr(nvap_pkg::IO_NV_CONTROL, 8'h01);
    u_cpu.io_rd(nvap_pkg::IO_NV_DATA_BYTE, v);
    chk("erased", 8'hff, v);
    $display("busy test done");
    ce_i <= 1'b0;
    u_cpu.io_wr(nvap_pkg::IO_NV_ADDRESS_LOW, 8'h55);
    ce_i <= 1'b1;
    u_cpu.io_rd(nvap_pkg::IO_NV_ADDRESS_LOW, v);
    chk("frozen_by_enable", 8'hff, v); // CLKEN
    $display("clock enable test done");
    end_of_test();
  end
endmodule // test_eeprom_access_port
